// file: hdl/aao_pkg.sv
package aao_pkg;

  // Machine state of the instruction sequencing inside the datapath.
  typedef enum logic [0:0] {
    AAO_ST_IDLE   = 1'b0,
    AAO_ST_SECOND = 1'b1
  } aao_state_t;

  // Data memory held in flip-flops; working registers sit at 0 to 7.
  localparam int unsigned DMEM_DEPTH = 64;
  localparam int unsigned DMEM_AW    = 6;

  // Reset values.
  localparam logic [7:0] ACC_RST   = 8'h00;
  localparam logic [7:0] DMEM_RST  = 8'h00;
  localparam logic       FLAG_RST  = 1'b0;

  // Whole-byte opcodes.
  localparam logic [7:0] OP_ADD_IMM  = 8'h03;
  localparam logic [7:0] OP_ADD_WITH_CARRY_OP_IMM = 8'h13;
  localparam logic [7:0] OP_AND_IMM  = 8'h53;
  localparam logic [7:0] OP_OR_IMM   = 8'h43;
  localparam logic [7:0] OP_XOR_IMM  = 8'hD3;
  localparam logic [7:0] OP_CPL      = 8'h37;
  localparam logic [7:0] OP_CLR      = 8'h27;
  localparam logic [7:0] OP_DA       = 8'h57;
  localparam logic [7:0] OP_DEC      = 8'h07;
  localparam logic [7:0] OP_INC      = 8'h17;
  localparam logic [7:0] OP_RL       = 8'hE7;
  localparam logic [7:0] OP_RLC      = 8'hF7;
  localparam logic [7:0] OP_RR       = 8'h77;
  localparam logic [7:0] OP_RRC      = 8'h67;
  localparam logic [7:0] OP_SWAP     = 8'h47;

  // Register-form groups, opcode bits 7 to 3; bits 2 to 0 pick the register.
  localparam logic [4:0] GRP_ADD_REG  = 5'h0D;
  localparam logic [4:0] GRP_ADD_WITH_CARRY_OP_REG = 5'h0F;
  localparam logic [4:0] GRP_AND_REG  = 5'h0B;
  localparam logic [4:0] GRP_OR_REG   = 5'h09;
  localparam logic [4:0] GRP_XOR_REG  = 5'h1B;
  localparam logic [4:0] GRP_DECREMENT_BRANCH_NONZERO_OP     = 5'h1D;

  // Indirect-form groups, opcode bits 7 to 1; bit 0 picks the pointer.
  localparam logic [6:0] GRP_ADD_IND  = 7'h30;
  localparam logic [6:0] GRP_ADD_WITH_CARRY_OP_IND = 7'h38;
  localparam logic [6:0] GRP_AND_IND  = 7'h28;
  localparam logic [6:0] GRP_OR_IND   = 7'h20;
  localparam logic [6:0] GRP_XOR_IND  = 7'h68;

  // Decimal adjust constants.
  localparam logic [3:0] BCD_LIMIT  = 4'h9;
  localparam logic [8:0] BCD_FIX_LO = 9'h006;
  localparam logic [8:0] BCD_FIX_HI = 9'h060;

endpackage

// file: hdl/aao_accumulator_alu.sv
// Contract
// - Opcode 03H adds the second byte in two cycles, new carry.
// - Opcodes 68H-6FH add register r in one cycle, new carry.
// - Opcodes 60H/61H add the byte that register 0 or 1 points at.
// - Opcode 13H adds second byte and carry in two cycles, sets carry.
// - Opcodes 78H-7FH add register r plus carry, one cycle, new carry.
// - Opcodes 70H/71H add the pointed byte plus carry in one cycle.
// - AND with data 53H, register 58H-5FH, pointer 50H/51H; flags kept.
// - OR with data 43H, register 48H-4FH, pointer 40H/41H; flags kept.
// - XOR with data D3H, register D8H-DFH, pointer D0H/D1H; flags kept.
// - Opcode 37H inverts the accumulator in one cycle, flags untouched.
// - Opcode 27H clears the accumulator in one cycle, flags untouched.
// - Opcode 57H decimal-adjusts the accumulator in one cycle.
// - Opcode 07H decrements the accumulator modulo 256; flags kept.
// - Opcode 17H increments the accumulator modulo 256; flags kept.
// - Opcode E7H rotates left, bit 7 into bit 0, carry untouched.
// - Opcode F7H rotates left through carry.
// - Opcode 77H rotates right, bit 0 into bit 7, carry untouched.
// - Opcode 67H rotates right through carry.
// - Opcode 47H swaps the accumulator nibbles in one cycle.
// - Opcodes E8H-EFH decrement r and branch to byte two when nonzero.
// - Only the flags an instruction is marked to affect may change.
module aao_accumulator_alu (
  // Clock and reset
  input  wire logic        SYS_CLK,
  input  wire logic        RESET_N,
  // Instruction issue from the sequencer
  input  wire logic        OP_VALID,
  input  wire logic [7:0]  OP_CODE,
  input  wire logic [7:0]  OP_ARG,
  output logic             OP_READY,
  output logic             OP_DONE,
  // Flag load from the status word
  input  wire logic        FLAG_LOAD,
  input  wire logic        FLAG_C_IN,
  input  wire logic        FLAG_AC_IN,
  // Data memory access port
  input  wire logic        MEM_WR_EN,
  input  wire logic [5:0]  MEM_WR_ADDR,
  input  wire logic [7:0]  MEM_WR_DATA,
  input  wire logic [5:0]  MEM_RD_ADDR,
  output logic [7:0]       MEM_RD_DATA,
  // Datapath state
  output logic [7:0]       ACC,
  output logic             CARRY,
  output logic             AUX_CARRY,
  // Branch to the program counter
  output logic             BRANCH_TAKEN,
  output logic [7:0]       BRANCH_ADDR
);

  aao_pkg::aao_state_t state;
  aao_pkg::aao_state_t next_state;
  logic [7:0]  held_op;
  logic [7:0]  next_held_op;
  logic [7:0]  held_arg;
  logic [7:0]  next_held_arg;
  logic [7:0]  next_acc;
  logic        next_carry;
  logic        next_aux_carry;
  logic        next_ready;
  logic        next_done;
  logic        next_branch;
  logic [7:0]  next_branch_addr;
  logic [7:0]  next_rd_data;
  logic [7:0]  dmem      [aao_pkg::DMEM_DEPTH];
  logic [7:0]  next_dmem [aao_pkg::DMEM_DEPTH];

  logic        exec_now;
  logic [7:0]  exec_op;
  logic [7:0]  exec_arg;
  logic [7:0]  reg_val;
  logic [5:0]  reg_idx;
  logic [7:0]  ptr_val;
  logic [7:0]  ind_val;
  logic [7:0]  operand;
  logic [8:0]  sum;
  logic        hit_add;
  logic        hit_add_with_carry_op;
  logic        hit_and;
  logic        hit_or;
  logic        hit_xor;
  logic        hit_decrement_branch_nonzero_op;
  logic        reg_wr;
  logic [7:0]  reg_wr_val;
  logic [8:0]  da_val;
  logic        da_carry;

  // Two-byte instructions hold the sequencer for a second machine cycle.
  function automatic logic two_byte(input logic [7:0] op);
    two_byte = (op == aao_pkg::OP_ADD_IMM) || (op == aao_pkg::OP_ADD_WITH_CARRY_OP_IMM) ||
               (op == aao_pkg::OP_AND_IMM) || (op == aao_pkg::OP_OR_IMM) ||
               (op == aao_pkg::OP_XOR_IMM) ||
               (op[7:3] == aao_pkg::GRP_DECREMENT_BRANCH_NONZERO_OP);
  endfunction

  // Sequencing: one-byte ops execute on the accepting edge.
  // Latching the second byte lets the sequencer move on once an op is taken.
  always_comb begin
    next_state    = state;
    next_held_op  = held_op;
    next_held_arg = held_arg;
    exec_now      = 1'b0;
    exec_op       = OP_CODE;
    exec_arg      = OP_ARG;
    case (state)
      aao_pkg::AAO_ST_IDLE: begin
        if (OP_VALID) begin
          if (two_byte(OP_CODE)) begin
            next_state    = aao_pkg::AAO_ST_SECOND;
            next_held_op  = OP_CODE;
            next_held_arg = OP_ARG;
          end else begin
            exec_now = 1'b1;
          end
        end
      end
      aao_pkg::AAO_ST_SECOND: begin
        exec_now   = 1'b1;
        exec_op    = held_op;
        exec_arg   = held_arg;
        next_state = aao_pkg::AAO_ST_IDLE;
      end
      default: begin
        next_state = aao_pkg::AAO_ST_IDLE;
      end
    endcase
    next_ready = (next_state == aao_pkg::AAO_ST_IDLE);
    next_done  = exec_now;
  end

  // Operand selection and decode.
  // Immediate forms end in bits 11; indirect forms use bit 0 as the pointer.
  always_comb begin
    reg_idx = {3'h0, exec_op[2:0]};
    reg_val = dmem[reg_idx];
    ptr_val = dmem[{5'h00, exec_op[0]}];
    ind_val = dmem[ptr_val[aao_pkg::DMEM_AW-1:0]];
    if (exec_op[3]) begin
      operand = reg_val;
    end else if (exec_op[1:0] == 2'b11) begin
      operand = exec_arg;
    end else begin
      operand = ind_val;
    end
    hit_add  = (exec_op == aao_pkg::OP_ADD_IMM) ||
               (exec_op[7:3] == aao_pkg::GRP_ADD_REG) ||
               (exec_op[7:1] == aao_pkg::GRP_ADD_IND);
    hit_add_with_carry_op = (exec_op == aao_pkg::OP_ADD_WITH_CARRY_OP_IMM) ||
               (exec_op[7:3] == aao_pkg::GRP_ADD_WITH_CARRY_OP_REG) ||
               (exec_op[7:1] == aao_pkg::GRP_ADD_WITH_CARRY_OP_IND);
    hit_and  = (exec_op == aao_pkg::OP_AND_IMM) ||
               (exec_op[7:3] == aao_pkg::GRP_AND_REG) ||
               (exec_op[7:1] == aao_pkg::GRP_AND_IND);
    hit_or   = (exec_op == aao_pkg::OP_OR_IMM) ||
               (exec_op[7:3] == aao_pkg::GRP_OR_REG) ||
               (exec_op[7:1] == aao_pkg::GRP_OR_IND);
    hit_xor  = (exec_op == aao_pkg::OP_XOR_IMM) ||
               (exec_op[7:3] == aao_pkg::GRP_XOR_REG) ||
               (exec_op[7:1] == aao_pkg::GRP_XOR_IND);
    hit_decrement_branch_nonzero_op = (exec_op[7:3] == aao_pkg::GRP_DECREMENT_BRANCH_NONZERO_OP);
    sum = {1'b0, ACC} + {1'b0, operand} +
          {8'h00, hit_add_with_carry_op & CARRY};
  end

  // Decimal adjust: low nibble first, then the high nibble.
  always_comb begin
    da_val = {1'b0, ACC};
    if ((ACC[3:0] > aao_pkg::BCD_LIMIT) || AUX_CARRY) begin
      da_val = da_val + aao_pkg::BCD_FIX_LO;
    end
    da_carry = CARRY | da_val[8];
    if ((da_val[7:4] > aao_pkg::BCD_LIMIT) || da_carry) begin
      da_val = {1'b0, da_val[7:0]} + aao_pkg::BCD_FIX_HI;
      da_carry = da_carry | da_val[8];
    end
  end

  // Accumulator, flags and branch. Unlisted opcodes leave everything alone.
  always_comb begin
    next_acc         = ACC;
    next_carry       = CARRY;
    next_aux_carry   = AUX_CARRY;
    next_branch      = 1'b0;
    next_branch_addr = BRANCH_ADDR;
    reg_wr           = 1'b0;
    reg_wr_val       = reg_val - 8'h01;
    // A load from the status word yields to an executing instruction.
    if (FLAG_LOAD && !exec_now) begin
      next_carry     = FLAG_C_IN;
      next_aux_carry = FLAG_AC_IN;
    end
    if (exec_now) begin
      if (hit_add || hit_add_with_carry_op) begin
        next_acc   = sum[7:0];
        next_carry = sum[8];
      end else if (hit_and) begin
        next_acc = ACC & operand;
      end else if (hit_or) begin
        next_acc = ACC | operand;
      end else if (hit_xor) begin
        next_acc = ACC ^ operand;
      end else if (hit_decrement_branch_nonzero_op) begin
        reg_wr = 1'b1;
        if (reg_wr_val != 8'h00) begin
          next_branch      = 1'b1;
          next_branch_addr = exec_arg;
        end
      end else begin
        case (exec_op)
          aao_pkg::OP_CPL:  next_acc = ~ACC;
          aao_pkg::OP_CLR:  next_acc = aao_pkg::ACC_RST;
          aao_pkg::OP_DA: begin
            next_acc   = da_val[7:0];
            next_carry = da_carry;
          end
          aao_pkg::OP_DEC:  next_acc = ACC - 8'h01;
          aao_pkg::OP_INC:  next_acc = ACC + 8'h01;
          aao_pkg::OP_RL:   next_acc = {ACC[6:0], ACC[7]};
          aao_pkg::OP_RLC: begin
            next_acc   = {ACC[6:0], CARRY};
            next_carry = ACC[7];
          end
          aao_pkg::OP_RR:   next_acc = {ACC[0], ACC[7:1]};
          aao_pkg::OP_RRC: begin
            next_acc   = {CARRY, ACC[7:1]};
            next_carry = ACC[0];
          end
          aao_pkg::OP_SWAP: next_acc = {ACC[3:0], ACC[7:4]};
          default:          next_acc = ACC;
        endcase
      end
    end
  end

  // Data memory: the decrement write of the branch op beats the port write.
  // The register index is widened before the compare, so bytes above the
  // working registers can never alias onto the one being decremented.
  for (genvar i = 0; i < aao_pkg::DMEM_DEPTH; i++) begin : g_dmem
    always_comb begin
      if (reg_wr && (reg_idx == 6'(i))) begin
        next_dmem[i] = reg_wr_val;
      end else if (MEM_WR_EN && (MEM_WR_ADDR == 6'(i))) begin
        next_dmem[i] = MEM_WR_DATA;
      end else begin
        next_dmem[i] = dmem[i];
      end
    end
  end

  always_comb begin
    next_rd_data = dmem[MEM_RD_ADDR];
  end

  // OP_READY is taken from the next state, so it never disagrees with it.
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      state    <= aao_pkg::AAO_ST_IDLE;
      held_op  <= 8'h00;
      held_arg <= 8'h00;
      OP_READY <= 1'b1;
      OP_DONE  <= 1'b0;
    end else begin
      state    <= next_state;
      held_op  <= next_held_op;
      held_arg <= next_held_arg;
      OP_READY <= next_ready;
      OP_DONE  <= next_done;
    end
  end

  // The branch target stays put until the next taken branch.
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      ACC          <= aao_pkg::ACC_RST;
      CARRY        <= aao_pkg::FLAG_RST;
      AUX_CARRY    <= aao_pkg::FLAG_RST;
      BRANCH_TAKEN <= 1'b0;
      BRANCH_ADDR  <= 8'h00;
    end else begin
      ACC          <= next_acc;
      CARRY        <= next_carry;
      AUX_CARRY    <= next_aux_carry;
      BRANCH_TAKEN <= next_branch;
      BRANCH_ADDR  <= next_branch_addr;
    end
  end

  // A read shows the byte as it stood before a write on the same edge.
  always_ff @(posedge SYS_CLK) begin
    if (!RESET_N) begin
      MEM_RD_DATA <= aao_pkg::DMEM_RST;
      for (int k = 0; k < aao_pkg::DMEM_DEPTH; k++) begin
        dmem[k] <= aao_pkg::DMEM_RST;
      end
    end else begin
      MEM_RD_DATA <= next_rd_data;
      dmem        <= next_dmem;
    end
  end

endmodule

// file: bench/aao_alu_assertions.sv
module aao_alu_chk (
  // Clock and reset
  input wire logic       SYS_CLK,
  input wire logic       RESET_N,
  // Instruction issue
  input wire logic       OP_VALID,
  input wire logic [7:0] OP_CODE,
  input wire logic [7:0] OP_ARG,
  input wire logic       OP_READY,
  input wire logic       OP_DONE,
  input wire logic       FLAG_LOAD,
  // Datapath state
  input wire logic [7:0] ACC,
  input wire logic       CARRY,
  input wire logic       AUX_CARRY,
  input wire logic       BRANCH_TAKEN
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);
  logic take;
  logic two;
  assign take = OP_VALID && OP_READY;
  assign two  = OP_CODE inside {8'h03, 8'h13, 8'h43, 8'h53, 8'hD3} ||
                OP_CODE[7:3] == 5'h1D;
  sequence s_hold; !OP_READY && !OP_DONE; endsequence
  sequence s_fin; OP_DONE && OP_READY; endsequence
  property p_one; take && !two |=> s_fin; endproperty
  a_one: assert property (p_one) else $error("short op late");
  property p_two; take && two |=> s_hold ##1 s_fin; endproperty
  a_two: assert property (p_two) else $error("long op timing");
  property p_add; take && OP_CODE == 8'h03 |=> ##1
    {CARRY, ACC} == {1'b0, $past(ACC, 2)} + {1'b0, $past(OP_ARG, 2)};
  endproperty
  a_add: assert property (p_add) else $error("add result");
  property p_inc; take && OP_CODE == 8'h17 |=>
    ACC == $past(ACC) + 8'h01 && $stable(CARRY); endproperty
  a_inc: assert property (p_inc) else $error("increment");
  property p_dec; take && OP_CODE == 8'h07 |=>
    ACC == $past(ACC) - 8'h01 && $stable(CARRY); endproperty
  a_dec: assert property (p_dec) else $error("decrement");
  property p_cpl; take && OP_CODE == 8'h37 |=> ACC == ~$past(ACC);
  endproperty
  a_cpl: assert property (p_cpl) else $error("complement");
  property p_clr; take && OP_CODE == 8'h27 |=> ACC == 8'h00; endproperty
  a_clr: assert property (p_clr) else $error("clear");
  property p_swap; take && OP_CODE == 8'h47 |=>
    ACC == {$past(ACC[3:0]), $past(ACC[7:4])}; endproperty
  a_swap: assert property (p_swap) else $error("swap");
  property p_rl; take && OP_CODE == 8'hE7 |=>
    ACC == {$past(ACC[6:0]), $past(ACC[7])} && $stable(CARRY); endproperty
  a_rl: assert property (p_rl) else $error("rotate left");
  property p_rlc; take && OP_CODE == 8'hF7 |=>
    {CARRY, ACC} == {$past(ACC), $past(CARRY)}; endproperty
  a_rlc: assert property (p_rlc) else $error("rotate left c");
  property p_rrc; take && OP_CODE == 8'h67 |=>
    {ACC, CARRY} == {$past(CARRY), $past(ACC)}; endproperty
  a_rrc: assert property (p_rrc) else $error("rotate right c");
  property p_aux; !FLAG_LOAD |=> $stable(AUX_CARRY); endproperty
  a_aux: assert property (p_aux) else $error("aux carry moved");
  property p_br; BRANCH_TAKEN |-> OP_DONE; endproperty
  a_br: assert property (p_br) else $error("stray branch");
endmodule

bind aao_accumulator_alu aao_alu_chk u_aao_alu_chk (
  .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .OP_VALID(OP_VALID),
  .OP_CODE(OP_CODE), .OP_ARG(OP_ARG), .OP_READY(OP_READY),
  .OP_DONE(OP_DONE), .FLAG_LOAD(FLAG_LOAD), .ACC(ACC), .CARRY(CARRY),
  .AUX_CARRY(AUX_CARRY), .BRANCH_TAKEN(BRANCH_TAKEN));

// file: bench/aao_seq_model.sv
module aao_seq_model (
  // Clock
  input wire logic  clk,
  // Issue handshake
  input wire logic  op_ready,
  input wire logic  op_done,
  output logic       op_valid,
  output logic [7:0] op_code,
  output logic [7:0] op_arg
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    op_valid = 1'b0;
    op_code = 8'h00;
    op_arg = 8'h00;
  end
  // Called at a falling edge. The request stays up until the result pulse,
  // so a two-byte op keeps its argument through its second cycle.
  task automatic issue(input logic [7:0] code, input logic [7:0] arg);
    int n;
    n = 0;
    while (op_ready !== 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    op_valid = 1'b1;
    op_code = code;
    op_arg = arg;
    do begin
      @(negedge clk);
      n++;
    end while (op_done !== 1'b1 && n < 16);
    op_valid = 1'b0;
    op_code = ~code;
    op_arg = ~arg;
  endtask
endmodule

// file: bench/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic       sys_clk = 1'b0;
  logic       reset_n = 1'b0;
  logic       op_valid, op_ready, op_done;
  logic [7:0] op_code, op_arg, acc, branch_addr, mem_rd_data;
  logic       flag_load = 1'b0, flag_c_in = 1'b0, flag_ac_in = 1'b0;
  logic       mem_wr_en = 1'b0;
  logic [5:0] mem_wr_addr = 6'h00, mem_rd_addr = 6'h00;
  logic [7:0] mem_wr_data = 8'h00;
  logic       carry, aux_carry, branch_taken;
  int         macc = 0, mc = 0, mac = 0, mtk = 0, i;
  int         mem [64] = '{default: 0};
  int         failures = 0, checked = 0, cycles = 0;
  logic [7:0] op, arg;
  logic [5:0] rd;
  logic [7:0] ops [26] = '{8'h03, 8'h13, 8'h53, 8'h43, 8'hD3, 8'h37,
    8'h27, 8'h57, 8'h07, 8'h17, 8'hE7, 8'hF7, 8'h77, 8'h67, 8'h47, 8'h60,
    8'h70, 8'h50, 8'h40, 8'hD0, 8'h68, 8'h78, 8'h58, 8'h48, 8'hD8, 8'hE8};
  always #5 sys_clk = ~sys_clk;
  aao_seq_model u_aao_seq_model (.clk(sys_clk), .op_ready(op_ready),
    .op_done(op_done), .op_valid(op_valid), .op_code(op_code),
    .op_arg(op_arg));
  aao_accumulator_alu u_aao_accumulator_alu (.SYS_CLK(sys_clk),
    .RESET_N(reset_n), .OP_VALID(op_valid), .OP_CODE(op_code),
    .OP_ARG(op_arg), .OP_READY(op_ready), .OP_DONE(op_done),
    .FLAG_LOAD(flag_load), .FLAG_C_IN(flag_c_in), .FLAG_AC_IN(flag_ac_in),
    .MEM_WR_EN(mem_wr_en), .MEM_WR_ADDR(mem_wr_addr),
    .MEM_WR_DATA(mem_wr_data), .MEM_RD_ADDR(mem_rd_addr),
    .MEM_RD_DATA(mem_rd_data), .ACC(acc), .CARRY(carry),
    .AUX_CARRY(aux_carry), .BRANCH_TAKEN(branch_taken),
    .BRANCH_ADDR(branch_addr));
  task automatic stop_test();
    if (failures == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input int exp, string what);
    checked++;
    if (got !== 8'(exp)) begin
      failures++;
      $display("wrong value at %0t: %s %h not %h", $time, what, got, 8'(exp));
    end
  endtask
  // Writes only between ops, so the decrement-branch never collides.
  task automatic wr(input int a, input int d);
    mem_wr_addr = 6'(a);
    mem_wr_data = 8'(d);
    mem_wr_en = 1'b1;
    mem[a] = d & 255;
    @(negedge sys_clk);
  endtask
  task automatic model(input logic [7:0] op, input logic [7:0] arg);
    int s, v;
    v = op[3] ? mem[op[2:0]] : (op[1:0] == 2'h3) ? int'(arg)
      : mem[mem[op[0]] & 63];
    mtk = 0;
    case (op)
      8'h37: macc = ~macc & 255;
      8'h27: macc = 0;
      8'h07: macc = (macc + 255) & 255;
      8'h17: macc = (macc + 1) & 255;
      8'hE7: macc = ((macc << 1) | (macc >> 7)) & 255;
      8'hF7: begin
        s = macc;
        macc = ((s << 1) | mc) & 255;
        mc = s >> 7;
      end
      8'h77: macc = ((macc >> 1) | (macc << 7)) & 255;
      8'h67: begin
        s = macc;
        macc = (s >> 1) | (mc << 7);
        mc = s & 1;
      end
      8'h47: macc = ((macc << 4) | (macc >> 4)) & 255;
      8'h57: begin
        s = macc;
        if ((s & 15) > 9 || mac) s = s + 6;
        if (((s >> 4) & 15) > 9 || mc || s > 255) s = s + 96;
        mc = mc | (s > 255);
        macc = s & 255;
      end
      default: case (op[7:4])
        4'h0, 4'h1, 4'h6, 4'h7: begin
          s = macc + v + (op[4] ? mc : 0);
          mc = s >> 8;
          macc = s & 255;
        end
        4'h5: macc = macc & v;
        4'h4: macc = macc | v;
        4'hD: macc = macc ^ v;
        default: begin
          mem[op[2:0]] = (mem[op[2:0]] + 255) & 255;
          mtk = mem[op[2:0]] != 0;
        end
      endcase
    endcase
  endtask
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      stop_test();
    end
  end
  initial begin
    void'($urandom(5169));
    repeat (3) @(negedge sys_clk);
    reset_n = 1'b1;
    @(negedge sys_clk);
    check(acc, 0, "reset acc");
    check({7'h00, op_ready}, 1, "reset ready");
    // The strobe stays up across back-to-back writes; it drops once after.
    for (i = 0; i < 64; i++) wr(i, $urandom);
    mem_wr_en = 1'b0;
    for (i = 0; i < 500; i++) begin
      if ($urandom % 4 == 0) begin
        flag_c_in = 1'($urandom);
        flag_ac_in = 1'($urandom);
        flag_load = 1'b1;
        mc = flag_c_in;
        mac = flag_ac_in;
        @(negedge sys_clk);
        flag_load = 1'b0;
      end
      // Small register values let the loop counter reach zero often.
      if ($urandom % 2 == 0) begin
        wr($urandom % 8, $urandom % 3);
        mem_wr_en = 1'b0;
      end
      op = ops[$urandom % 26];
      if (op[3]) op[2:0] = 3'($urandom);
      else if (op[3:0] == 4'h0) op[0] = 1'($urandom);
      arg = 8'($urandom);
      rd = op[3] ? {3'h0, op[2:0]} : 6'($urandom);
      model(op, arg);
      u_aao_seq_model.issue(op, arg);
      check(acc, macc, "acc");
      check({7'h00, carry}, mc, "carry");
      check({7'h00, aux_carry}, mac, "aux carry");
      check({7'h00, branch_taken}, mtk, "branch");
      if (mtk) check(branch_addr, arg, "target");
      mem_rd_addr = rd;
      @(negedge sys_clk);
      check(mem_rd_data, mem[rd], "memory");
    end
    reset_n = 1'b0;
    repeat (3) @(negedge sys_clk);
    reset_n = 1'b1;
    @(negedge sys_clk);
    check(acc, 0, "reset acc");
    check({6'h00, carry, aux_carry}, 0, "reset flags");
    check({7'h00, op_ready}, 1, "reset ready");
    check(mem_rd_data, 0, "reset memory");
    stop_test();
  end
endmodule
